//--- overcurrent_fault_responder.sv
// Purpose: decide the converter reaction to an output over-current fault
// Assumes: sense comparators and the command decoder are synchronous to sys_clk_i
// Notes: time unit length is supplied as a cycle count from a separate register
`timescale 1ns/1ps
`include "ocp_resp_consts.svh"

// Summary of operation
// - every over-current event that arrives in the run state sets the fault flag and pulses a host notification whatever the response mode.
// - mode 00 keeps running and clamps current at the fault threshold forever, ignoring voltage.
// - mode 01 clamps current while output voltage stays above the cutoff, then shuts down and applies the retry setting.
// - mode 10 clamps current for the programmed delay and applies the retry setting if still limiting at its end.
// - mode 11 shuts the output down at once and then follows the retry setting.
// - the three-bit retry field sets the attempt count, and zero means stay off until the fault is cleared.
// - a retry field of all ones retries without limit.
// - retry values one to five allow that many attempts, then the output stays off until cleared.
// - restart attempts start one delay interval apart, two to the power of the delay code times the time unit.
// - the delay code selects a power-of-two count of time units from 1 to 128.
// - retry value six allows six attempts, then the output stays off until cleared.
// - continuous retrying stops only on an off command, loss of bias power, another shutdown fault or a fault clear.
module overcurrent_fault_responder (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic cfg_wr_i,
  input wire logic [7:0] cfg_cmd_i,
  input wire logic [7:0] cfg_wdata_i,
  output logic [7:0] cfg_rdata_o,
  input wire logic [15:0] unit_cycles_i,
  input wire logic over_current_i,
  input wire logic under_voltage_i,
  input wire logic output_on_cmd_i,
  input wire logic bias_ok_i,
  input wire logic other_fault_i,
  input wire logic fault_clear_i,
  output logic output_enable_o,
  output logic current_limit_o,
  output logic fault_flag_o,
  output logic notify_o,
  output ocp_resp_pkg::resp_state_t state_o,
  output logic [2:0] attempts_o
);
  import ocp_resp_pkg::*;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // power-of-two unit count for a delay code
  function automatic logic [7:0] delay_units(input logic [2:0] code);
    delay_units = 8'h01 << code;
  endfunction

  // where a shutdown goes: latched off when no restart is allowed, else wait for a retry
  function automatic resp_state_t shut_state(input logic [2:0] retries);
    shut_state = (retries == `RETRY_NONE) ? ST_LATCHED : ST_WAIT;
  endfunction

  // true on the last unit of a delay or retry interval
  function automatic logic interval_end(input logic [7:0] units, input logic [2:0] code);
    interval_end = (units + 8'h01 >= delay_units(code));
  endfunction

  // configuration, sequencer state and counters
  action_cfg_t cfg_reg;
  resp_state_t state_reg;
  logic [15:0] presc_reg;
  logic tick;
  logic [7:0] units_reg;
  logic [2:0] attempts_reg;
  logic fault_reg;
  logic notify_reg;
  logic abort;
  logic fire;

  // ------------------------------------------------------------
  // response register
  // ------------------------------------------------------------
  // write only when the command code selects this register
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cfg_reg <= action_cfg_t'(`OCA_RESET_VAL);
    end else if (cfg_wr_i && cfg_cmd_i == `OCA_CMD_CODE) begin
      cfg_reg <= action_cfg_t'(cfg_wdata_i);
    end
  end

  // reads of other codes return zero
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cfg_rdata_o <= 8'h00;
    end else begin
      cfg_rdata_o <= (cfg_cmd_i == `OCA_CMD_CODE) ? cfg_reg : 8'h00;
    end
  end

  // an off command, bias loss or another fault ends any sequence
  assign abort = !output_on_cmd_i || !bias_ok_i || other_fault_i;
  // a fault is reported once, on leaving run; one that persists while limiting is not reported again
  assign fire = over_current_i && (state_reg == ST_RUN);

  // ------------------------------------------------------------
  // time unit prescaler
  // ------------------------------------------------------------
  // the prescaler runs only while timing; held at zero otherwise, but not cleared on a mode 01 shutdown from limit to wait, so that wait can start mid-unit
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || !(state_reg == ST_LIMIT || state_reg == ST_WAIT)) begin
      presc_reg <= 16'h0000;
    end else if (tick) begin
      presc_reg <= 16'h0000;
    end else begin
      presc_reg <= presc_reg + 16'h0001;
    end
  end
  assign tick = (presc_reg + 16'h0001 >= unit_cycles_i);

  // ------------------------------------------------------------
  // fault sequencer
  // ------------------------------------------------------------
  // one process owns state, unit timer and attempt count so they move together
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_RUN;
      units_reg <= 8'h00;
      attempts_reg <= 3'h0;
    end else if (abort || fault_clear_i) begin
      state_reg <= ST_RUN;
      units_reg <= 8'h00;
      attempts_reg <= 3'h0;
    end else begin
      unique case (state_reg)
        ST_RUN: begin
          if (over_current_i) begin
            units_reg <= 8'h00;
            unique case (cfg_reg.mode)
              RESP_IGNORE: state_reg <= ST_LIMIT;
              RESP_COND_LIMIT: state_reg <= ST_LIMIT;
              RESP_DELAY_LIMIT: state_reg <= ST_LIMIT;
              RESP_SHUTDOWN: begin
                state_reg <= shut_state(cfg_reg.retries);
              end
            endcase
          end
        end
        ST_LIMIT: begin
          if (!over_current_i && cfg_reg.mode != RESP_DELAY_LIMIT) begin
            state_reg <= ST_RUN;
          end else if (cfg_reg.mode == RESP_COND_LIMIT && under_voltage_i) begin
            units_reg <= 8'h00;
            state_reg <= shut_state(cfg_reg.retries);
          end else if (cfg_reg.mode == RESP_DELAY_LIMIT && tick) begin
            if (interval_end(units_reg, cfg_reg.delay_code)) begin
              units_reg <= 8'h00;
              if (!over_current_i) begin
                state_reg <= ST_RUN;
              end else begin
                state_reg <= shut_state(cfg_reg.retries);
              end
            end else begin
              units_reg <= units_reg + 8'h01;
            end
          end
        end
        ST_WAIT: begin
          // output off, count one interval then attempt a restart
          if (tick) begin
            if (interval_end(units_reg, cfg_reg.delay_code)) begin
              units_reg <= 8'h00;
              state_reg <= ST_RUN;
              if (cfg_reg.retries != `RETRY_FOREVER) begin
                attempts_reg <= attempts_reg + 3'h1;
              end
            end else begin
              units_reg <= units_reg + 8'h01;
            end
          end
        end
        ST_LATCHED: begin
          state_reg <= ST_LATCHED;
        end
        default: begin
          // the four unused codes of the state word fall back to idle
          state_reg <= ST_RUN;
        end
      endcase
      // a fault right after the last allowed attempt latches off; mode 00 never shuts down,
      // so attempts left over from an earlier setting must not latch it
      if (state_reg == ST_RUN && over_current_i && cfg_reg.mode != RESP_IGNORE
          && cfg_reg.retries != `RETRY_FOREVER && attempts_reg >= cfg_reg.retries && attempts_reg != 3'h0) begin
        state_reg <= ST_LATCHED;
      end
    end
  end

  // ------------------------------------------------------------
  // fault flag and notification
  // ------------------------------------------------------------
  // set wins over clear so a fault in the clear cycle is kept
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      fault_reg <= 1'b0;
      notify_reg <= 1'b0;
    end else begin
      notify_reg <= fire;
      if (fire) begin
        fault_reg <= 1'b1;
      end else if (fault_clear_i) begin
        fault_reg <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // enable drops at once on an off command or bias loss, a cycle before the sequencer resets
  assign output_enable_o = output_on_cmd_i && bias_ok_i && (state_reg == ST_RUN || state_reg == ST_LIMIT);
  assign current_limit_o = (state_reg == ST_LIMIT);
  assign fault_flag_o = fault_reg;
  assign notify_o = notify_reg;
  assign state_o = state_reg;
  assign attempts_o = attempts_reg;
endmodule

//--- ocp_resp_consts.svh
// Purpose: constants for the over-current fault responder
// Assumes: 125 MHz system clock
// Notes: field positions follow the response byte layout
`ifndef OCP_RESP_CONSTS_SVH
`define OCP_RESP_CONSTS_SVH
`define OCA_CMD_CODE 8'h47
`define OCA_RESET_VAL 8'h00
`define OCA_RESP_HI 7
`define OCA_RESP_LO 6
`define OCA_RETRY_HI 5
`define OCA_RETRY_LO 3
`define OCA_DELAY_HI 2
`define OCA_DELAY_LO 0
`define RETRY_NONE 3'h0
`define RETRY_FOREVER 3'h7
`define CLK_PERIOD_NS 8
`endif

//--- ocp_resp_pkg.sv
// Purpose: types for the over-current fault responder
// Assumes: nothing
// Notes: response codes match the two-bit response field
package ocp_resp_pkg;
  typedef enum logic [1:0] {
    RESP_IGNORE = 2'h0,
    RESP_COND_LIMIT = 2'h1,
    RESP_DELAY_LIMIT = 2'h2,
    RESP_SHUTDOWN = 2'h3
  } resp_mode_t;
  typedef struct packed {
    resp_mode_t mode;
    logic [2:0] retries;
    logic [2:0] delay_code;
  } action_cfg_t;
  typedef enum logic [2:0] {
    ST_RUN = 3'h0,
    ST_LIMIT = 3'h1,
    ST_WAIT = 3'h3,
    ST_LATCHED = 3'h2
  } resp_state_t;
endpackage

//--- ocr_assertions.sv
// Purpose: port checker for the over-current responder
// Assumes: bound to every responder instance
// Notes: ok means no off command, bias loss, other fault or clear
`timescale 1ns/1ps
module ocr_checker
  import ocp_resp_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic over_current_i,
  input wire logic output_on_cmd_i,
  input wire logic bias_ok_i,
  input wire logic other_fault_i,
  input wire logic fault_clear_i,
  input wire logic output_enable_o,
  input wire logic current_limit_o,
  input wire logic fault_flag_o,
  input wire logic notify_o,
  input wire resp_state_t state_o,
  input wire logic [2:0] attempts_o
);
  logic ok;
  // aborts win over everything, so three checks hold only while ok
  assign ok = output_on_cmd_i && bias_ok_i && !other_fault_i && !fault_clear_i;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_hit; state_o == ST_RUN && over_current_i && ok; endsequence
  sequence s_latched; state_o == ST_LATCHED && ok; endsequence
  property p_take; s_hit |=> notify_o && fault_flag_o && state_o != ST_RUN; endproperty
  a_take: assert property (p_take) else $error("fault not taken");
  property p_pulse; notify_o |=> !notify_o; endproperty
  a_pulse: assert property (p_pulse) else $error("notify too long");
  property p_flag; notify_o |-> fault_flag_o; endproperty
  a_flag: assert property (p_flag) else $error("notify without flag");
  property p_clamp; state_o == ST_LIMIT && ok |-> current_limit_o && output_enable_o; endproperty
  a_clamp: assert property (p_clamp) else $error("limit not clamping");
  property p_wait_off; state_o == ST_WAIT |-> !output_enable_o; endproperty
  a_wait_off: assert property (p_wait_off) else $error("output on while waiting");
  property p_latch_off; state_o == ST_LATCHED |-> !output_enable_o && !current_limit_o; endproperty
  a_latch_off: assert property (p_latch_off) else $error("output on while latched");
  property p_hold; s_latched |=> state_o == ST_LATCHED; endproperty
  a_hold: assert property (p_hold) else $error("latch left without clear");
  property p_abort; !output_on_cmd_i |=> state_o == ST_RUN && attempts_o == 3'h0; endproperty
  a_abort: assert property (p_abort) else $error("off command not reset");
  property p_fault_abort; !bias_ok_i || other_fault_i |=> state_o == ST_RUN && attempts_o == 3'h0; endproperty
  a_fault_abort: assert property (p_fault_abort) else $error("bias loss or other fault not reset");
endmodule
bind overcurrent_fault_responder ocr_checker u_chk (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
  .over_current_i(over_current_i), .output_on_cmd_i(output_on_cmd_i), .bias_ok_i(bias_ok_i),
  .other_fault_i(other_fault_i), .fault_clear_i(fault_clear_i), .output_enable_o(output_enable_o),
  .current_limit_o(current_limit_o), .fault_flag_o(fault_flag_o), .notify_o(notify_o),
  .state_o(state_o), .attempts_o(attempts_o));

//--- ocr_host.sv
// Purpose: host side model issuing register writes and selects
// Assumes: byte command interface synchronous to the system clock
// Notes: write data is inverted once released so stale data never matches
`timescale 1ns/1ps
module ocr_host (
  input wire logic clk_i,
  output logic wr_o,
  output logic [7:0] cmd_o,
  output logic [7:0] data_o
);
  initial begin
    wr_o = 1'b0;
    cmd_o = 8'h00;
    data_o = 8'h00;
  end
  // one-cycle strobe; the command stays selected for read back
  task automatic put(input logic [7:0] c, input logic [7:0] d, input logic w);
    @(posedge clk_i);
    wr_o <= w;
    cmd_o <= c;
    data_o <= d;
    @(posedge clk_i);
    wr_o <= 1'b0;
    data_o <= ~d;
  endtask
endmodule

//--- overcurrent_fault_responder_bench.sv
// Purpose: self-checking bench for the over-current responder
// Assumes: time unit of two cycles; bias and other-fault inputs move only in the abort scenario
// Notes: under-voltage is raised only in the conditioned-limit scenario
`timescale 1ns/1ps
module overcurrent_fault_responder_bench;
  import ocp_resp_pkg::*;
  localparam int U = 2;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0, oc = 1'b0, on = 1'b1, clr = 1'b0, uv = 1'b0, bias = 1'b1, oth = 1'b0;
  logic wr, en, lim, flag, ntf;
  logic [7:0] cmd, wdata, rdata;
  logic [2:0] att;
  resp_state_t st;
  int mismatches = 0, compares = 0, cyc = 0;
  always #4 sys_clk = ~sys_clk;
  ocr_host host (.clk_i(sys_clk), .wr_o(wr), .cmd_o(cmd), .data_o(wdata));
  overcurrent_fault_responder dut (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .cfg_wr_i(wr), .cfg_cmd_i(cmd),
    .cfg_wdata_i(wdata), .cfg_rdata_o(rdata), .unit_cycles_i(16'(U)), .over_current_i(oc),
    .under_voltage_i(uv), .output_on_cmd_i(on), .bias_ok_i(bias), .other_fault_i(oth),
    .fault_clear_i(clr), .output_enable_o(en), .current_limit_o(lim), .fault_flag_o(flag),
    .notify_o(ntf), .state_o(st), .attempts_o(att));
  task automatic ck(input logic good, input string msg);
    compares++;
    if (good !== 1'b1) begin
      mismatches++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic summarize;
    if (mismatches == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic hit;
    @(posedge sys_clk) oc <= 1'b1;
    @(posedge sys_clk) oc <= 1'b0;
    #1;
    ck(ntf === 1'b1 && flag === 1'b1, "no notify");
  endtask
  task automatic wait_off(input resp_state_t s, output int n);
    n = 0;
    while (st === s && n < 600) begin
      step(1);
      n++;
    end
  endtask
  task automatic t_reg;
    host.put(8'h47, 8'h00, 1'b0);
    step(1);
    ck(rdata === 8'h00, "bad reset value");
    host.put(8'h47, 8'hC9, 1'b1);
    host.put(8'h46, 8'h3F, 1'b1);
    host.put(8'h47, 8'h00, 1'b0);
    step(1);
    ck(rdata === 8'hC9, "bad read back");
  endtask
  task automatic t_ignore;
    host.put(8'h47, 8'h00, 1'b1);
    @(posedge sys_clk) oc <= 1'b1;
    step(20);
    ck(st === ST_LIMIT && lim === 1'b1 && en === 1'b1, "not clamping");
    @(posedge sys_clk) oc <= 1'b0;
    step(2);
    ck(st === ST_RUN, "clamp stuck");
  endtask
  task automatic t_delay;
    int n;
    host.put(8'h47, 8'h80, 1'b1);
    @(posedge sys_clk) oc <= 1'b1;
    step(1);
    wait_off(ST_LIMIT, n);
    ck(st === ST_LATCHED && n >= U - 1 && n <= U + 1, "bad delay");
    @(posedge sys_clk) oc <= 1'b0;
    on <= 1'b0;
    @(posedge sys_clk) on <= 1'b1;
    #1;
    ck(st === ST_RUN, "off ignored");
  endtask
  // mode 01: clamp while voltage holds, shut down once it sags
  task automatic t_cond;
    host.put(8'h47, 8'h40, 1'b1);
    @(posedge sys_clk) oc <= 1'b1;
    step(3);
    ck(st === ST_LIMIT && lim === 1'b1 && en === 1'b1, "no conditioned clamp");
    @(posedge sys_clk) uv <= 1'b1;
    step(1);
    ck(st === ST_LATCHED && en === 1'b0, "no under-voltage shutdown");
    @(posedge sys_clk) begin
      oc <= 1'b0;
      uv <= 1'b0;
      clr <= 1'b1;
    end
    @(posedge sys_clk) clr <= 1'b0;
    #1;
    ck(st === ST_RUN && flag === 1'b0, "clear ignored");
  endtask
  // a continuous retry sequence ends at once on bias loss or another fault
  task automatic t_abort;
    host.put(8'h47, 8'hFB, 1'b1);
    hit();
    @(posedge sys_clk) bias <= 1'b0;
    @(posedge sys_clk) bias <= 1'b1;
    #1;
    ck(st === ST_RUN && att === 3'h0, "bias loss ignored");
    hit();
    ck(st === ST_WAIT, "no shutdown");
    @(posedge sys_clk) oth <= 1'b1;
    @(posedge sys_clk) oth <= 1'b0;
    #1;
    ck(st === ST_RUN && en === 1'b1, "other fault ignored");
  endtask
  // k faults that must restart, then one more that ends latched or waiting
  task automatic retry_run(input logic [7:0] c, input int k, input logic ends);
    int n;
    int exp;
    host.put(8'h47, c, 1'b1);
    exp = U * (1 << c[2:0]);
    for (int i = 0; i < k; i++) begin
      hit();
      ck(st === ST_WAIT && en === 1'b0, "no shutdown");
      wait_off(ST_WAIT, n);
      ck(st === ST_RUN && n >= exp - 1 && n <= exp + 1, "bad interval");
      ck(att === 3'(i + 1) || c[5:3] == 3'h7, "bad attempt count");
    end
    hit();
    ck(st === (ends ? ST_LATCHED : ST_WAIT), "bad end state");
    @(posedge sys_clk) clr <= 1'b1;
    @(posedge sys_clk) clr <= 1'b0;
    #1;
    ck(st === ST_RUN && att === 3'h0 && flag === 1'b0, "clear ignored");
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reg();
    t_ignore();
    t_delay();
    t_cond();
    t_abort();
    retry_run(8'hC0, 0, 1'b1);
    retry_run(8'hC9, 1, 1'b1);
    retry_run(8'hF1, 6, 1'b1);
    retry_run(8'hFA, 8, 1'b0);
    summarize();
  end
endmodule
